// File: pifl_regs.vh
// Register offsets, field positions, reset values and masks of the flag block
`ifndef PIFL_REGS_VH
`define PIFL_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PIFL_OFS_FLAGS3     12'h000
`define PIFL_OFS_FLAGS4     12'h004
`define PIFL_OFS_FLAGS5     12'h008
`define PIFL_OFS_STATUS     12'h00C
`define PIFL_OFS_MASK       12'h010
`define PIFL_OFS_PINSEL     12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PIFL_F3_TMR0        7
`define PIFL_F3_U1SUM       6
`define PIFL_F3_U1ERR       5
`define PIFL_F3_U1TX        4
`define PIFL_F3_U1RX        3
`define PIFL_F3_T1ERR       2
`define PIFL_F3_T1SUM       1
`define PIFL_F3_T1TX        0
`define PIFL_F5_EXT1        0

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define PIFL_W1C_MASK3      8'h80
`define PIFL_W1C_MASK4      8'hEF
`define PIFL_W1C_MASK5      8'h3F
`define PIFL_FLAG_RESET     8'h00
`define PIFL_WORD_RESET     32'h0000_0000
`define PIFL_PINSEL_RESET   3'h0
`define PIFL_STATUS_BITS    3

`endif

// File: pifl_flag_reg.v
// One 8-bit flag register with sticky hardware-set and live read-only bits
`include "pifl_regs.vh"

module pifl_flag_reg #(
    parameter [7:0] W1C_MASK = 8'h00
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [7:0] hw_set,
    input  wire [7:0] live_src,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output wire [7:0] flags
);
    reg  [7:0] sticky_q;
    wire [7:0] sticky_d;

    // Set beats clear; writes of one clear, zero leaves alone
    assign sticky_d = ((sticky_q & ~({8{wr_en}} & wr_data & W1C_MASK))
                      | hw_set) & W1C_MASK;

    // Sticky flags start clear on every reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sticky_q <= `PIFL_FLAG_RESET;
        else
            sticky_q <= sticky_d;
    end

    // Read-only bits follow their source, unimplemented read zero
    assign flags = sticky_q | (live_src & ~W1C_MASK);
endmodule

// File: pifl_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels
module pifl_sync #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: pifl_top.v
// Peripheral interrupt request flag registers three to five behind APB
//
// Local design decisions: the register addresses and register access over APB.
`include "pifl_regs.vh"

module pifl_top #(
    parameter EXT_PINS = 8
) (
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output wire                pready,
    output wire                pslverr,
    output reg  [31:0]         prdata,
    input  wire                timer_zero_evt,
    input  wire                uart_irq_reg_any,
    input  wire                uart_error_irq_reg_any,
    input  wire                uart_one_tx_req,
    input  wire                uart_one_rx_req,
    input  wire                twi_error_reg_any,
    input  wire                twi_irq_reg_any,
    input  wire                twi_one_tx_req,
    input  wire [6:0]          flags4_evt,
    input  wire                twi_two_tx_req,
    input  wire                twi_two_rx_req,
    input  wire [3:0]          dma_two_evt,
    input  wire                comparator_two_evt,
    input  wire [EXT_PINS-1:0] ext_irq_pins,
    output wire [7:0]          flags3,
    output wire [7:0]          flags4,
    output wire [7:0]          flags5,
    output wire                irq
);
    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire       wr_acc;
    wire       hit;
    wire       wr_f3;
    wire       wr_f4;
    wire       wr_f5;
    wire       wr_st;
    wire       wr_mk;
    wire       wr_ps;

    // Register hit check for one offset
    function sel_reg;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            sel_reg = (addr == ofs);
        end
    endfunction

    assign pready  = 1'b1;
    assign wr_acc  = psel & penable & pwrite & pstrb[0];
    assign hit     = sel_reg(paddr, `PIFL_OFS_FLAGS3) | sel_reg(paddr, `PIFL_OFS_FLAGS4)
                   | sel_reg(paddr, `PIFL_OFS_FLAGS5) | sel_reg(paddr, `PIFL_OFS_STATUS)
                   | sel_reg(paddr, `PIFL_OFS_MASK)   | sel_reg(paddr, `PIFL_OFS_PINSEL);
    assign pslverr = psel & penable & ~hit;
    assign wr_f3   = wr_acc & sel_reg(paddr, `PIFL_OFS_FLAGS3);
    assign wr_f4   = wr_acc & sel_reg(paddr, `PIFL_OFS_FLAGS4);
    assign wr_f5   = wr_acc & sel_reg(paddr, `PIFL_OFS_FLAGS5);
    assign wr_st   = wr_acc & sel_reg(paddr, `PIFL_OFS_STATUS);
    assign wr_mk   = wr_acc & sel_reg(paddr, `PIFL_OFS_MASK);
    assign wr_ps   = wr_acc & sel_reg(paddr, `PIFL_OFS_PINSEL);

    // ------------------------------------------------------------------------
    // External interrupt one pin select and edge detect
    // ------------------------------------------------------------------------
    reg  [2:0]          ext_irq_pin_select_q;
    reg                 ext_level_q;
    wire [EXT_PINS-1:0] pins_sync;
    wire                ext_level;
    wire                ext_rise;

    pifl_sync #(
        .WIDTH    (EXT_PINS)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ext_irq_pins),
        .sync_out (pins_sync)
    );

    // Chosen pin feeds the external flag
    assign ext_level = pins_sync[ext_irq_pin_select_q];
    assign ext_rise  = ext_level & ~ext_level_q;

    // Pin select register and edge history
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_irq_pin_select_q <= `PIFL_PINSEL_RESET;
            ext_level_q          <= 1'b0;
        end
        else
        begin
            if (wr_ps)
                ext_irq_pin_select_q <= pwdata[2:0];
            ext_level_q <= ext_level;
        end
    end

    // ------------------------------------------------------------------------
    // Flag registers
    // ------------------------------------------------------------------------
    wire [7:0] set3;
    wire [7:0] live3;
    wire [7:0] set4;
    wire [7:0] set5;
    wire [7:0] live5;

    assign set3  = {timer_zero_evt, 7'h00};
    // Summary bits follow their source registers, no software path
    assign live3 = {1'b0, uart_irq_reg_any,
                    uart_error_irq_reg_any,
                    uart_one_tx_req, uart_one_rx_req,
                    twi_error_reg_any,
                    twi_irq_reg_any,
                    twi_one_tx_req};
    assign set4  = {flags4_evt[6:4], 1'b0, flags4_evt[3:0]};
    assign set5  = {2'b00, dma_two_evt, comparator_two_evt,
                    ext_rise};
    assign live5 = {twi_two_tx_req, twi_two_rx_req, 6'h00};

    pifl_flag_reg #(
        .W1C_MASK (`PIFL_W1C_MASK3)
    ) u_flags3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set3),
        .live_src (live3),
        .wr_en    (wr_f3),
        .wr_data  (pwdata[7:0]),
        .flags    (flags3)
    );

    pifl_flag_reg #(
        .W1C_MASK (`PIFL_W1C_MASK4)
    ) u_flags4 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set4),
        .live_src (8'h00),
        .wr_en    (wr_f4),
        .wr_data  (pwdata[7:0]),
        .flags    (flags4)
    );

    pifl_flag_reg #(
        .W1C_MASK (`PIFL_W1C_MASK5)
    ) u_flags5 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set5),
        .live_src (live5),
        .wr_en    (wr_f5),
        .wr_data  (pwdata[7:0]),
        .flags    (flags5)
    );

    // ------------------------------------------------------------------------
    // Summary status, mask and interrupt line
    // ------------------------------------------------------------------------
    reg  [2:0] status_q;
    reg  [2:0] mask_q;
    reg  [2:0] any_q;
    wire [2:0] any_now;
    wire [2:0] status_d;

    // One status bit per flag register, set on rising activity
    assign any_now  = {|flags5, |flags4, |flags3};
    assign status_d = (status_q & ~({3{wr_st}} & pwdata[2:0]))
                    | (any_now & ~any_q);

    // Status, mask and activity history
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= 3'h0;
            mask_q   <= 3'h0;
            any_q    <= 3'h0;
        end
        else
        begin
            status_q <= status_d;
            any_q    <= any_now;
            if (wr_mk)
                mask_q <= pwdata[2:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Registered read data, loaded in the setup phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= `PIFL_WORD_RESET;
        else if (psel & ~penable & ~pwrite)
        begin
            case (paddr)
                `PIFL_OFS_FLAGS3: prdata <= {24'h000000, flags3};
                `PIFL_OFS_FLAGS4: prdata <= {24'h000000, flags4};
                `PIFL_OFS_FLAGS5: prdata <= {24'h000000, flags5};
                `PIFL_OFS_STATUS: prdata <= {29'h0000000, status_q};
                `PIFL_OFS_MASK:   prdata <= {29'h0000000, mask_q};
                `PIFL_OFS_PINSEL: prdata <= {29'h0000000, ext_irq_pin_select_q};
                default:          prdata <= `PIFL_WORD_RESET;
            endcase
        end
    end
endmodule

// File: pifl_sva.sv
// Assertion checker for the peripheral flag block
`include "pifl_regs.vh"
module pifl_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        timer_zero_evt,
    input wire        uart_one_tx_req,
    input wire        twi_one_tx_req,
    input wire        twi_two_tx_req,
    input wire [6:0]  flags4_evt,
    input wire [3:0]  dma_two_evt,
    input wire        comparator_two_evt,
    input wire [7:0]  flags3,
    input wire [7:0]  flags4,
    input wire [7:0]  flags5
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Properties
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write-one access aimed at timer one's flag
    sequence s_clr4;
        psel && penable && pwrite && paddr == `PIFL_OFS_FLAGS4 && pstrb[0] && pwdata[0];
    endsequence
    // One-cycle comparator event
    sequence s_cmp;
        comparator_two_evt ##1 !comparator_two_evt;
    endsequence
    property p_tmr; timer_zero_evt |=> flags3[7]; endproperty
    property p_f4; flags4_evt[0] |=> flags4[0]; endproperty
    property p_clr4; s_clr4 ##0 !flags4_evt[0] |=> !flags4[0]; endproperty
    property p_gap; flags4[4] == 1'h0; endproperty
    property p_ro3; flags3[4] == uart_one_tx_req && flags3[0] == twi_one_tx_req; endproperty
    property p_ro5; flags5[7] == twi_two_tx_req; endproperty
    property p_dma; $rose(dma_two_evt[3]) |=> flags5[5]; endproperty
    property p_cmp; s_cmp |-> flags5[1]; endproperty
    property p_hold; flags5[1] && !psel |=> flags5[1]; endproperty
    a_tmr: assert property (p_tmr) else $error("timer flag not set");
    a_f4: assert property (p_f4) else $error("flags4 bit 0 not set");
    a_clr4: assert property (p_clr4) else $error("flags4 bit 0 not cleared");
    a_gap: assert property (p_gap) else $error("flags4 bit 4 not zero");
    a_ro3: assert property (p_ro3) else $error("flags3 live bit wrong");
    a_ro5: assert property (p_ro5) else $error("flags5 bit 7 wrong");
    a_dma: assert property (p_dma) else $error("dma abort flag not set");
    a_cmp: assert property (p_cmp) else $error("comparator flag not set");
    a_hold: assert property (p_hold) else $error("comparator flag lost");
endmodule
bind pifl_top pifl_sva i_pifl_sva (.*);

// File: pifl_peer.sv
// Peripheral event source model facing the flag block
module pifl_peer (
    output wire [8:0] src_lv
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] uir_q = 8'h00;
    reg [7:0] uerr_q = 8'h00;
    reg [7:0] terr_q = 8'h00;
    reg [7:0] tir_q = 8'h00;
    reg [4:0] req_q = 5'h00;
    // Summaries stay high while any source bit is set
    assign src_lv = {|uir_q, |uerr_q, req_q[4:3], |terr_q, |tir_q, req_q[2:0]};
    // Buffer clear drops all three TWI requests
    task clear_buf;
        req_q[2:0] <= 3'h0;
    endtask
endmodule

// File: pifl_bench.sv
// Self-checking bench for the peripheral flag block
`include "pifl_regs.vh"
module pifl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [3:0]  pstrb = 4'hF;
    logic        timer_zero_evt = 1'h0, comparator_two_evt = 1'h0, serr;
    logic [6:0]  flags4_evt = 7'h00;
    logic [3:0]  dma_two_evt = 4'h0;
    logic [7:0]  ext_irq_pins = 8'h00;
    wire         pready, pslverr, irq;
    wire  [31:0] prdata;
    wire  [7:0]  flags3, flags4, flags5;
    wire  [8:0]  src_lv;
    wire         uart_irq_reg_any, uart_error_irq_reg_any, uart_one_tx_req, uart_one_rx_req;
    wire         twi_error_reg_any, twi_irq_reg_any, twi_one_tx_req, twi_two_tx_req, twi_two_rx_req;
    integer      n_errors = 0, num_checks = 0;
    assign {uart_irq_reg_any, uart_error_irq_reg_any, uart_one_tx_req, uart_one_rx_req,
            twi_error_reg_any, twi_irq_reg_any, twi_one_tx_req, twi_two_tx_req, twi_two_rx_req} = src_lv;
    always #20 pclk = ~pclk;
    pifl_top i_pifl_top (.*);
    pifl_peer i_pifl_peer (.src_lv(src_lv));
    // ----
    // Shared tasks
    // ----
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // APB setup, access, then wait for pready
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer k;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'h1)
                break;
        end
        if (k == 20)
        begin
            n_errors++;
            stop_test;
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string n);
        xfer(1'h0, a, 32'h0);
        chk(n, rdat, e);
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        rd(`PIFL_OFS_FLAGS3, 32'h0, "flags3");
        rd(`PIFL_OFS_FLAGS4, 32'h0, "flags4");
        rd(`PIFL_OFS_FLAGS5, 32'h0, "flags5");
    endtask
    task t_tmr;
        @(posedge pclk) timer_zero_evt <= 1'h1;
        @(posedge pclk) timer_zero_evt <= 1'h0;
        rd(`PIFL_OFS_FLAGS3, 32'h80, "timer set");
        fork
            xfer(1'h1, `PIFL_OFS_FLAGS3, 32'hFF);
            begin
                repeat (2) @(posedge pclk);
                timer_zero_evt <= 1'h1;
                @(posedge pclk) timer_zero_evt <= 1'h0;
            end
        join
        rd(`PIFL_OFS_FLAGS3, 32'h80, "set wins");
        xfer(1'h1, `PIFL_OFS_FLAGS3, 32'h80);
        rd(`PIFL_OFS_FLAGS3, 32'h0, "timer clear");
    endtask
    task t_live;
        @(posedge pclk);
        i_pifl_peer.uir_q <= 8'h06;
        i_pifl_peer.uerr_q <= 8'h01;
        i_pifl_peer.terr_q <= 8'h80;
        i_pifl_peer.tir_q <= 8'h10;
        i_pifl_peer.req_q <= 5'h1F;
        xfer(1'h1, `PIFL_OFS_FLAGS3, 32'h7F);
        rd(`PIFL_OFS_FLAGS3, 32'h7F, "live");
        rd(`PIFL_OFS_FLAGS5, 32'hC0, "twi two");
        i_pifl_peer.uir_q <= 8'h02;
        i_pifl_peer.uerr_q <= 8'h00;
        i_pifl_peer.terr_q <= 8'h00;
        i_pifl_peer.tir_q <= 8'h00;
        i_pifl_peer.req_q[4:3] <= 2'h0;
        i_pifl_peer.clear_buf;
        rd(`PIFL_OFS_FLAGS3, 32'h40, "one left");
        rd(`PIFL_OFS_FLAGS5, 32'h0, "buf clear");
        i_pifl_peer.uir_q <= 8'h00;
        rd(`PIFL_OFS_FLAGS3, 32'h0, "summary");
    endtask
    task t_f4;
        integer i;
        for (i = 0; i < 7; i++)
        begin
            @(posedge pclk) flags4_evt <= 7'h01 << i;
            @(posedge pclk) flags4_evt <= 7'h00;
            rd(`PIFL_OFS_FLAGS4, 32'h1 << (i < 4 ? i : i + 1), "flags4 bit");
            xfer(1'h1, `PIFL_OFS_FLAGS4, 32'hFF);
        end
        @(posedge pclk) flags4_evt <= 7'h7F;
        @(posedge pclk) flags4_evt <= 7'h00;
        xfer(1'h1, `PIFL_OFS_FLAGS4, 32'h0);
        rd(`PIFL_OFS_FLAGS4, 32'hEF, "flags4 all");
        // Write with byte lane 0 off must not clear anything
        pstrb <= 4'hE;
        xfer(1'h1, `PIFL_OFS_FLAGS4, 32'hFF);
        pstrb <= 4'hF;
        rd(`PIFL_OFS_FLAGS4, 32'hEF, "lane off");
        xfer(1'h1, `PIFL_OFS_FLAGS4, 32'hFF);
        rd(`PIFL_OFS_FLAGS4, 32'h0, "flags4 clr");
    endtask
    task t_f5;
        @(posedge pclk);
        dma_two_evt <= 4'hF;
        comparator_two_evt <= 1'h1;
        @(posedge pclk);
        dma_two_evt <= 4'h0;
        comparator_two_evt <= 1'h0;
        rd(`PIFL_OFS_FLAGS5, 32'h3E, "dma cmp");
        xfer(1'h1, `PIFL_OFS_PINSEL, 32'h3);
        rd(`PIFL_OFS_PINSEL, 32'h3, "pinsel");
        ext_irq_pins <= 8'h01;
        rd(`PIFL_OFS_FLAGS5, 32'h3E, "other pin");
        ext_irq_pins <= 8'h09;
        repeat (4) @(posedge pclk);
        rd(`PIFL_OFS_FLAGS5, 32'h3F, "pin set");
        xfer(1'h1, `PIFL_OFS_FLAGS5, 32'h3F);
        rd(`PIFL_OFS_FLAGS5, 32'h0, "flags5 clr");
        // Pins back to idle, a high pin would look like an edge after reset
        ext_irq_pins <= 8'h00;
    endtask
    task t_irq;
        xfer(1'h1, `PIFL_OFS_STATUS, 32'h7);
        xfer(1'h1, `PIFL_OFS_MASK, 32'h2);
        rd(`PIFL_OFS_MASK, 32'h2, "mask");
        @(posedge pclk) flags4_evt <= 7'h01;
        @(posedge pclk) flags4_evt <= 7'h00;
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(`PIFL_OFS_STATUS, 32'h2, "status");
        xfer(1'h1, `PIFL_OFS_FLAGS4, 32'h1);
        xfer(1'h1, `PIFL_OFS_STATUS, 32'h2);
        @(posedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        rd(12'h018, 32'h0, "unmapped");
        chk("slverr", {31'h0, serr}, 32'h1);
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset;
        t_tmr;
        t_live;
        t_f4;
        t_f5;
        t_irq;
        @(posedge pclk) timer_zero_evt <= 1'h1;
        @(posedge pclk) timer_zero_evt <= 1'h0;
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_reset;
        stop_test;
    end
endmodule
